// *** pkg/timer_pkg.sv ***
package timer_pkg;

  // ==========================================================
  // Register byte addresses (low eight address bits).
  localparam logic [7:0] CONTROL_ADDR    = 8'h88;
  localparam logic [7:0] MODE_ADDR       = 8'h8c;
  localparam logic [7:0] LOW0_ADDR       = 8'h90;
  localparam logic [7:0] HIGH0_ADDR      = 8'h94;
  localparam logic [7:0] LOW1_ADDR       = 8'h98;
  localparam logic [7:0] HIGH1_ADDR      = 8'h9c;
  localparam logic [7:0] AUX_ADDR        = 8'ha0;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'ha4;
  localparam logic [7:0] IRQ_CLEAR_ADDR  = 8'ha8;
  localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hac;

  // ==========================================================
  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [5:0] MODE_RESET    = 6'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [1:0] AUX_RESET     = 2'h0;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  // ==========================================================
  // Counter constants.
  localparam logic [7:0] COUNT_MAX      = 8'hff;
  localparam logic [7:0] COUNT_STEP     = 8'h01;
  localparam logic [7:0] PWM_FORCE_HIGH = 8'h00;
  localparam logic [7:0] PWM_FORCE_LOW  = 8'hff;

  // ==========================================================
  // Field layouts.
  typedef enum logic [2:0]
  {
    MODE_PRESCALE  = 3'b000,
    MODE_WIDE      = 3'b001,
    MODE_RELOAD    = 3'b010,
    MODE_SPLIT     = 3'b011,
    MODE_RSVD4     = 3'b100,
    MODE_RSVD5     = 3'b101,
    MODE_PWM       = 3'b110,
    MODE_RSVD7     = 3'b111
  } mode_type;

  typedef struct packed
  {
    logic       timer1OverflowFlag;
    logic       timer1RunBit;
    logic       timer0OverflowFlag;
    logic       timer0RunBit;
    logic [3:0] reserved;
  } control_type;

  typedef struct packed
  {
    mode_type timer1Mode;
    mode_type timer0Mode;
  } mode_reg_type;

  typedef struct packed
  {
    logic countSourceSelect;
    logic overflowToggleEnable;
  } aux_type;

  typedef struct packed
  {
    logic timer1;
    logic timer0;
  } irq_type;

endpackage

// *** hdl/timer_split_pwm_toggle.sv ***
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps

// Function
// - Timer 1 in its split mode stops counting, as if its run bit were cleared.
// - Timer 0 split mode runs low and high bytes as independent 8-bit counters.
// - Split high byte counts clocks, gated by timer 1 run, sets timer 1 flag.
// - Timer 1 starts/stops by leaving/entering split mode, raising no flag then.
// - Timer 0 PWM mode has a full period of 256 timer clocks.
// - In PWM mode hardware both sets and clears the timer 0 overflow flag.
// - PWM high phase of the flag lasts 256 minus the high byte value.
// - PWM high byte 00h forces pin high; FFh forces pin low.
// - PWM flag rising edge still interrupts; software may still clear the flag.
// - Timer 1 flag set on overflow, cleared on service or by software.
// - Control bit 6 runs timer 1; control bit 4 runs timer 0.
// - With toggle enabled the timer 0 pin inverts on each timer 0 overflow.
// - When toggle is switched on the pin reads 1 until the first overflow.
// - Mode field 011 is split, 110 is PWM; 100, 101, 111 are reserved.
// - Outside split and PWM, low byte overflow sets the flag and reloads low byte from high byte.
module timer_split_pwm_toggle
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        timer0PinIn,
  output logic             timer0PinOut,
  output logic             timer0PinOe,
  input  wire logic        timer0Serviced,
  input  wire logic        timer1Serviced,
  output logic             timer1Overflow,
  output logic             irq
);

  // ==========================================================
  // Bus slave.
  // Every access completes with no wait state, so the data
  // phase is always one cycle and the answer is always OKAY.
  logic       writePending;
  logic       dataHit;
  logic [7:0] dataAddr;

  wire addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      writePending <= 1'b0;
      dataHit      <= 1'b0;
      dataAddr     <= 8'h00;
    end
    else if (addrPhase)
    begin
      writePending <= hwrite;
      dataHit      <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
      dataAddr     <= haddr[7:0];
    end
    else
    begin
      writePending <= 1'b0;
    end
  end

  function automatic logic writeTo(input logic [7:0] target);
    writeTo = writePending && dataHit && (dataAddr == target);
  endfunction

  wire wrControl = writeTo(timer_pkg::CONTROL_ADDR);
  wire wrMode    = writeTo(timer_pkg::MODE_ADDR);
  wire wrLow0    = writeTo(timer_pkg::LOW0_ADDR);
  wire wrHigh0   = writeTo(timer_pkg::HIGH0_ADDR);
  wire wrLow1    = writeTo(timer_pkg::LOW1_ADDR);
  wire wrHigh1   = writeTo(timer_pkg::HIGH1_ADDR);
  wire wrAux     = writeTo(timer_pkg::AUX_ADDR);
  wire wrClear   = writeTo(timer_pkg::IRQ_CLEAR_ADDR);
  wire wrIrqEn   = writeTo(timer_pkg::IRQ_ENABLE_ADDR);

  wire timer_pkg::control_type wrControlData = timer_pkg::control_type'(hwdata[7:0]);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // Registers.
  timer_pkg::control_type  control;
  timer_pkg::mode_reg_type modeReg;
  timer_pkg::aux_type      aux;
  timer_pkg::irq_type      irqStatus;
  timer_pkg::irq_type      irqEnable;
  logic [7:0]              timer0LowCount;
  logic [7:0]              timer0HighCount;
  logic [7:0]              timer1LowCount;
  logic [7:0]              timer1HighCount;
  logic                    pwmHigh;
  logic                    toggleLevel;

  // ==========================================================
  // Count pin synchroniser for counter operation.
  logic pinMeta;
  logic pinSync;
  logic pinPrev;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      pinPrev <= 1'b0;
    end
    else
    begin
      pinMeta <= timer0PinIn;
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  wire pinFall = pinPrev && !pinSync;

  // ==========================================================
  // Mode decode.
  wire splitMode  = modeReg.timer0Mode == timer_pkg::MODE_SPLIT;
  wire pwmMode    = modeReg.timer0Mode == timer_pkg::MODE_PWM;
  wire timer1Held = modeReg.timer1Mode == timer_pkg::MODE_SPLIT;

  // ==========================================================
  // Timer 0 low byte.
  // Modes outside split and PWM fall back to the auto-reload
  // structure; the narrower prescaled modes are not built here.
  wire low0Tick = control.timer0RunBit
                && (aux.countSourceSelect ? pinFall : 1'b1);
  wire low0Wrap = low0Tick && (timer0LowCount == timer_pkg::COUNT_MAX);

  // Going high reloads the high byte, so the high phase lasts
  // 256 minus it; going low reloads its negation, so the low
  // phase lasts the high byte itself and the period is 256.
  wire [7:0] negHigh   = 8'h00 - timer0HighCount;
  wire [7:0] reloadVal = (pwmMode && pwmHigh) ? negHigh
                                              : timer0HighCount;
  wire [7:0] low0Inc   = timer0LowCount + timer_pkg::COUNT_STEP;

  logic [7:0] next_timer0LowCount;
  assign next_timer0LowCount = wrLow0 ? hwdata[7:0]
                             : !low0Tick ? timer0LowCount
                             : splitMode ? low0Inc
                             : low0Wrap ? reloadVal
                             : low0Inc;

  // ==========================================================
  // Timer 0 overflow flag.
  // A hardware set wins over both hardware and software clears.
  wire flag0Set = low0Wrap && !(pwmMode && pwmHigh);
  wire flag0HwClear = timer0Serviced
                    || (pwmMode && pwmHigh && low0Wrap);

  logic next_timer0Flag;
  assign next_timer0Flag = flag0Set ? 1'b1
                         : flag0HwClear ? 1'b0
                         : wrControl ? wrControlData.timer0OverflowFlag
                         : control.timer0OverflowFlag;

  // ==========================================================
  // Timer 0 high byte.
  // In split mode it counts every clock and borrows timer 1's
  // run bit, whatever the count source select says.
  wire high0Tick = splitMode && control.timer1RunBit;
  wire high0Wrap = high0Tick && (timer0HighCount == timer_pkg::COUNT_MAX);

  logic [7:0] next_timer0HighCount;
  assign next_timer0HighCount = wrHigh0 ? hwdata[7:0]
                              : high0Tick ? (timer0HighCount + timer_pkg::COUNT_STEP)
                              : timer0HighCount;

  // ==========================================================
  // Timer 1 as an 8-bit auto-reload baud source.
  // While timer 0 is split, timer 1 runs whenever it is out of
  // its own split mode, since its run bit belongs to timer 0.
  wire t1Run = !timer1Held
             && (splitMode ? 1'b1 : control.timer1RunBit);
  wire t1Wrap = t1Run && (timer1LowCount == timer_pkg::COUNT_MAX);

  logic [7:0] next_timer1LowCount;
  assign next_timer1LowCount = wrLow1 ? hwdata[7:0]
                             : t1Wrap ? timer1HighCount
                             : t1Run ? (timer1LowCount + timer_pkg::COUNT_STEP)
                             : timer1LowCount;

  wire t1Set = splitMode ? high0Wrap : t1Wrap;

  logic next_timer1Flag;
  assign next_timer1Flag = t1Set ? 1'b1
                         : timer1Serviced ? 1'b0
                         : wrControl ? wrControlData.timer1OverflowFlag
                         : control.timer1OverflowFlag;

  // ==========================================================
  // Control register.
  // Reserved bits are not stored and read as zero.
  timer_pkg::control_type next_control;
  assign next_control.timer1OverflowFlag = next_timer1Flag;
  assign next_control.timer1RunBit = wrControl ? wrControlData.timer1RunBit
                                               : control.timer1RunBit;
  assign next_control.timer0OverflowFlag = next_timer0Flag;
  assign next_control.timer0RunBit = wrControl ? wrControlData.timer0RunBit
                                               : control.timer0RunBit;
  assign next_control.reserved = 4'h0;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      control         <= timer_pkg::control_type'(timer_pkg::CONTROL_RESET);
      timer0LowCount  <= timer_pkg::COUNT_RESET;
      timer0HighCount <= timer_pkg::COUNT_RESET;
      timer1LowCount  <= timer_pkg::COUNT_RESET;
    end
    else
    begin
      control         <= next_control;
      timer0LowCount  <= next_timer0LowCount;
      timer0HighCount <= next_timer0HighCount;
      timer1LowCount  <= next_timer1LowCount;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      modeReg         <= timer_pkg::mode_reg_type'(timer_pkg::MODE_RESET);
      aux             <= timer_pkg::aux_type'(timer_pkg::AUX_RESET);
      timer1HighCount <= timer_pkg::COUNT_RESET;
      irqEnable       <= timer_pkg::irq_type'(timer_pkg::IRQ_RESET);
    end
    else
    begin
      if (wrMode)
        modeReg <= timer_pkg::mode_reg_type'(hwdata[5:0]);
      if (wrAux)
        aux <= timer_pkg::aux_type'(hwdata[1:0]);
      if (wrHigh1)
        timer1HighCount <= hwdata[7:0];
      if (wrIrqEn)
        irqEnable <= timer_pkg::irq_type'(hwdata[1:0]);
    end
  end

  // ==========================================================
  // PWM phase and pin drive.
  wire pwmLevel = (timer0HighCount == timer_pkg::PWM_FORCE_HIGH) ? 1'b1
                : (timer0HighCount == timer_pkg::PWM_FORCE_LOW) ? 1'b0
                : pwmHigh;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pwmHigh     <= 1'b0;
      toggleLevel <= 1'b1;
    end
    else
    begin
      if (!pwmMode)
        pwmHigh <= 1'b0;
      else if (low0Wrap)
        pwmHigh <= !pwmHigh;
      if (!aux.overflowToggleEnable)
        toggleLevel <= 1'b1;
      else if (low0Wrap)
        toggleLevel <= !toggleLevel;
    end
  end

  // The pin lags its cause by one clock so that it comes
  // straight from a flip-flop; PWM takes precedence over toggle.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      timer0PinOut   <= 1'b1;
      timer0PinOe    <= 1'b0;
      timer1Overflow <= 1'b0;
    end
    else
    begin
      timer0PinOut   <= pwmMode ? pwmLevel : toggleLevel;
      timer0PinOe    <= pwmMode || aux.overflowToggleEnable;
      timer1Overflow <= t1Wrap;
    end
  end

  // ==========================================================
  // Interrupt status.
  // Events are rising edges of the overflow flags; an event in
  // the same cycle as a clear write keeps its bit set.
  wire flag0Rise = next_timer0Flag && !control.timer0OverflowFlag;
  wire t1Rise    = next_timer1Flag && !control.timer1OverflowFlag;

  timer_pkg::irq_type clearMask;
  assign clearMask = wrClear ? timer_pkg::irq_type'(hwdata[1:0])
                             : timer_pkg::irq_type'(2'b00);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irqStatus <= timer_pkg::irq_type'(timer_pkg::IRQ_RESET);
    else
    begin
      irqStatus.timer0 <= flag0Rise || (irqStatus.timer0 && !clearMask.timer0);
      irqStatus.timer1 <= t1Rise || (irqStatus.timer1 && !clearMask.timer1);
    end
  end

  assign irq = |(irqStatus & irqEnable);

  // ==========================================================
  // Read mux.
  logic [7:0] readByte;

  always_comb
  begin
    readByte = 8'h00;
    case (dataAddr)
      timer_pkg::CONTROL_ADDR:    readByte = control;
      timer_pkg::MODE_ADDR:       readByte = {2'b00, modeReg};
      timer_pkg::LOW0_ADDR:       readByte = timer0LowCount;
      timer_pkg::HIGH0_ADDR:      readByte = timer0HighCount;
      timer_pkg::LOW1_ADDR:       readByte = timer1LowCount;
      timer_pkg::HIGH1_ADDR:      readByte = timer1HighCount;
      timer_pkg::AUX_ADDR:        readByte = {6'h00, aux};
      timer_pkg::IRQ_STATUS_ADDR: readByte = {6'h00, irqStatus};
      timer_pkg::IRQ_ENABLE_ADDR: readByte = {6'h00, irqEnable};
      default:                    readByte = 8'h00;
    endcase
  end

  assign hrdata = dataHit ? {24'h000000, readByte} : 32'h00000000;

endmodule

// *** bench/timer_split_pwm_toggle_properties.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port-level checker with bus-decoded shadows of the mode state.
module timer_split_pwm_toggle_properties
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        timer0PinIn,
  input wire logic        timer0PinOut,
  input wire logic        timer0PinOe,
  input wire logic        timer0Serviced,
  input wire logic        timer1Serviced,
  input wire logic        timer1Overflow,
  input wire logic        irq
);
  logic       dpOn;
  logic       dpWr;
  logic [7:0] dpA;
  logic [7:0] th;
  logic [5:0] md;
  logic       tog;
  logic [1:0] ien;
  wire        wrNow = dpOn && dpWr;
  wire        pwm   = md[2:0] == 3'b110;

  // Shadows follow data-phase writes so they change on the same edge as the registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      {dpOn, th, md, tog, ien} <= '0;
    end
    else
    begin
      dpOn <= hsel && htrans[1] && hready;
      dpWr <= hwrite;
      dpA  <= haddr[7:0];
      if (wrNow && dpA == 8'h94) th <= hwdata[7:0];
      if (wrNow && dpA == 8'h8c) md <= hwdata[5:0];
      if (wrNow && dpA == 8'ha0) tog <= hwdata[0];
      if (wrNow && dpA == 8'hac) ien <= hwdata[1:0];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence pwmHoldS(logic [7:0] v);
    (pwm && th == v) [*3];
  endsequence
  sequence quietS;
    !pwm && !tog;
  endsequence

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_RESET_OUT: assert property (disable iff (1'b0) !rst_n |=> !irq && timer0PinOut && !timer0PinOe && !timer1Overflow)
    else $error("outputs wrong after reset");
  AST_RSVD_READ: assert property (dpOn && !dpWr && dpA == 8'h88 |-> hrdata[3:0] == 4'h0)
    else $error("reserved control bits not zero");
  AST_HOLE_READ: assert property (dpOn && !dpWr && (dpA == 8'h40 || dpA == 8'ha8) |-> hrdata == 32'h0)
    else $error("unmapped or clear register read not zero");
  AST_FORCE_HIGH: assert property (pwmHoldS(8'h00) |-> timer0PinOut && timer0PinOe)
    else $error("pin not forced high");
  AST_FORCE_LOW: assert property (pwmHoldS(8'hff) |-> !timer0PinOut)
    else $error("pin not forced low");
  AST_OE_OFF: assert property (quietS [*3] |-> !timer0PinOe)
    else $error("pin driven while idle");
  AST_OE_ON: assert property ((pwm || tog) [*3] |-> timer0PinOe)
    else $error("pin not driven");
  AST_T1_STOP: assert property ((md[5:3] == 3'b011) [*3] |-> !timer1Overflow)
    else $error("timer 1 counts in split mode");
  AST_TOG_START: assert property (quietS ##1 tog |-> timer0PinOut)
    else $error("toggle did not start high");
  AST_IRQ_MASK: assert property ((ien == 2'b00) [*2] |-> !irq)
    else $error("masked interrupt raised");
endmodule

bind timer_split_pwm_toggle timer_split_pwm_toggle_properties timer_split_pwm_toggle_properties_inst
(
  .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .timer0PinIn(timer0PinIn), .timer0PinOut(timer0PinOut), .timer0PinOe(timer0PinOe),
  .timer0Serviced(timer0Serviced), .timer1Serviced(timer1Serviced), .timer1Overflow(timer1Overflow), .irq(irq)
);

// *** bench/tb_timer_split_pwm_toggle.sv ***
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench driving the bus and service inputs directly.
module tb_timer_split_pwm_toggle;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'b00;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic        svc0     = 1'b0;
  logic        svc1     = 1'b0;
  logic        pinIn    = 1'b1;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         pinOut;
  wire         pinOe;
  logic        t1Ovf;
  logic        irq;
  int          errors = 0;
  int          checks = 0;
  logic [31:0] d;
  int          n;

  timer_split_pwm_toggle timer_split_pwm_toggle_inst
  (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timer0PinIn(pinIn), .timer0PinOut(pinOut), .timer0PinOe(pinOe), .timer0Serviced(svc0),
    .timer1Serviced(svc1), .timer1Overflow(t1Ovf), .irq(irq)
  );

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_sim;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask

  // Ready is sampled in the active region just after the edge, before any update lands.
  task automatic edgeRdy;
    int k;
    k = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 20) begin errors++; end_sim(); end
      @(posedge core_clk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    edgeRdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    edgeRdy();
    d = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    xfer(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask

  // Length in cycles of the next whole stretch of the pin at the given level.
  task automatic meas(input logic lvl, output int len);
    int k;
    k   = 0;
    len = 0;
    while (pinOut === lvl && k < 600) begin @(posedge core_clk); k++; end
    while (pinOut !== lvl && k < 600) begin @(posedge core_clk); k++; end
    while (pinOut === lvl && len < 600) begin @(posedge core_clk); len++; end
    if (k >= 600) begin errors++; end_sim(); end
  endtask

  task automatic waitHigh(ref logic s);
    int k;
    for (k = 0; k < 300 && s !== 1'b1; k++) @(posedge core_clk);
    if (k >= 300) begin errors++; end_sim(); end
  endtask

  task automatic testRegs;
    rd(8'h88); chk(d, 32'h0);
    wr(8'h40, 8'h55); rd(8'h40); chk(d, 32'h0);
    rd(8'ha8); chk(d, 32'h0);
    chk({irq, pinOut, pinOe}, 3'b010);
    $display("registers test done");
  endtask

  task automatic testReload;
    logic [2:0] m [4] = '{3'b010, 3'b100, 3'b101, 3'b111};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h8c, {5'h0, m[i]}); wr(8'h94, 8'hf0); wr(8'ha0, 8'h01);
      wr(8'h88, 8'h10);
      chk({pinOut, pinOe}, 2'b11);
      meas(1'b0, n); chk(n, 16);
      meas(1'b1, n); chk(n, 16);
      rd(8'h88); chk(d & 32'h20, 32'h20);
      wr(8'h88, 8'h00); wr(8'ha0, 8'h00);
    end
    $display("reload toggle test done");
  endtask

  task automatic testPwm;
    logic [7:0] f [2] = '{8'h00, 8'hff};
    logic       bad;
    // Status is cleared before enabling so that the interrupt check sees only this run.
    wr(8'h8c, 8'h06); wr(8'h94, 8'h40); wr(8'ha8, 8'h01); wr(8'hac, 8'h01);
    wr(8'h88, 8'h10);
    meas(1'b1, n); chk(n, 192);
    rd(8'h88); chk(d & 32'h20, 32'h0);
    meas(1'b0, n); chk(n, 64);
    chk(irq, 1'b1);
    wr(8'ha8, 8'h01); @(posedge core_clk); chk(irq, 1'b0);
    wr(8'hac, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h94, f[i]);
      repeat (600) @(posedge core_clk);
      bad = 1'b0;
      repeat (300) begin @(posedge core_clk); bad |= (pinOut !== ~f[i][0]); end
      chk(bad, 1'b0);
    end
    wr(8'h88, 8'h00); wr(8'h8c, 8'h00);
    $display("pwm test done");
  endtask

  // With count source select set, only synchronised falling pin edges advance the low byte.
  task automatic testPin;
    wr(8'h8c, 8'h02);
    wr(8'ha0, 8'h02);
    wr(8'h88, 8'h10);
    repeat (5)
    begin
      pinIn <= 1'b0;
      repeat (3) @(posedge core_clk);
      pinIn <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
    rd(8'h90);
    chk(d, 32'h5);
    wr(8'h88, 8'h00);
    wr(8'ha0, 8'h00);
    $display("pin count test done");
  endtask

  task automatic testSplit;
    wr(8'h90, 8'h00); wr(8'h94, 8'h00); wr(8'h8c, 8'h1b); wr(8'hac, 8'h02);
    wr(8'h88, 8'h50);
    waitHigh(irq);
    rd(8'h88); chk(d & 32'hf0, 32'hf0);
    wr(8'h8c, 8'h13);
    waitHigh(t1Ovf);
    wr(8'h88, 8'ha0);
    svc0 <= 1'b1; svc1 <= 1'b1;
    @(posedge core_clk);
    svc0 <= 1'b0; svc1 <= 1'b0;
    rd(8'h88); chk(d, 32'h0);
    wr(8'ha8, 8'h02); @(posedge core_clk); chk(irq, 1'b0);
    $display("split test done");
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    testRegs();
    testPin();
    testReload();
    testPwm();
    testSplit();
    end_sim();
  end
endmodule
